// ==== tsa_map.svh ====
// Constant map of the time slot assigner: word fields, counts and reset values
`ifndef TSA_MAP_SVH
`define TSA_MAP_SVH

`define TSA_WORD_BITS 8
`define TSA_MODE_FIRST 7
`define TSA_MODE_SECOND 6
`define TSA_SLOT_MSB 5
`define TSA_SLOT_LSB 0
`define TSA_CTRL_MSB 7
`define TSA_CTRL_LSB 5
`define TSA_ADDR_MSB 4
`define TSA_ADDR_LSB 0
`define TSA_BIT_LAST 3'h7
`define TSA_SLOT_SHIFT 3
`define TSA_ACK_DELAY 2'h3
`define TSA_CNT_IDLE 10'h200
`define TSA_CNT_FIRST 10'h000
`define TSA_CTRL_RESET 3'h0
`define TSA_SLOT_RESET 6'h00
`define TSA_PD_RESET 1'b1

`endif

// ==== tsa_pkg.sv ====
// Types shared by the time slot assigner
package tsa_pkg;

   typedef enum logic [1:0] {
      TSA_MODE_BOTH = 2'h0,
      TSA_MODE_TX = 2'h1,
      TSA_MODE_RX = 2'h2,
      TSA_MODE_IDLE = 2'h3
   } tsa_mode_type;

   typedef enum logic [1:0] {
      TSA_ACK_IDLE = 2'h0,
      TSA_ACK_WAIT = 2'h1,
      TSA_ACK_LOW = 2'h3
   } tsa_ack_state_type;

endpackage : tsa_pkg

// ==== tsa_slot_assigner.sv ====
// Per-channel time slot assigner with serial programming port
// Notes on behaviour
// - Serial input bits are sampled on the falling serial clock edge.
// - Port pins are asynchronous; all are synchronised before use.
// - Mode word: two mode bits first, then six slot bits.
// - Address word: three line control bits first, then five address bits.
// - Both words shift together on the same serial clock edges.
// - Full variant accepts only when address equals identity inputs.
// - Ring clear high forces line control bit two to zero.
// - Acknowledge low three data clocks after next frame sync, released on following one.
// - Only the accepting device pulls the acknowledge low.
// - Data clock divided by eight gives the slot rate.
// - Full variant times both directions from data clock a.
// - Compact variant times receive slots from data clock b.
// - Frame sync rising edges fix slot zero of each frame.
// - Data clock edge meeting frame sync rise is bit zero of slot zero.
// - Transmit and receive slot zero may differ by whole bits.
// - Each slot enable is high eight data clocks once per frame.
// - Slot position is slot number times eight clocks after frame sync.
// - Accepted data loads line control; mode selects which slot registers load.
// - Accepted slot data becomes active on next transmit frame sync rise.
// - Compact variant accepts whenever chip select is high, no address check.
// - Compact power down output high unless mode both ones, then low.
// - Compact hook bus carries inverted hook input in transmit slot, even disabled.
`include "tsa_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tsa_slot_assigner #(
   parameter bit FULL_FEATURE = 1'b1
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic serial_clock_i,
   input wire logic chip_select_i,
   input wire logic mode_slot_serial_in_i,
   input wire logic addr_ctrl_serial_in_i,
   input wire logic [4:0] hardwired_identity_inputs_i,
   input wire logic ring_control_clear_i,
   input wire logic bit_rate_clock_a_i,
   input wire logic bit_rate_clock_b_i,
   input wire logic tx_frame_sync_i,
   input wire logic rx_frame_sync_i,
   input wire logic hook_state_in_i,
   output logic tx_slot_enable_o,
   output logic rx_slot_enable_o,
   output logic line_ctrl_bit_zero_o,
   output logic line_ctrl_bit_one_o,
   output logic line_ctrl_bit_two_o,
   output logic line_power_down_n_o,
   output logic accept_ack_n_o,
   output logic accept_ack_oe_n_o,
   output logic hook_state_bus_n_o,
   output logic hook_state_bus_oe_n_o
);
   import tsa_pkg::*;

   default clocking dflt_cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   function automatic logic [9:0] next_count(input logic [9:0] cnt,
                                             input logic sync_edge,
                                             input logic run);
      logic [9:0] res;
      res = cnt;
      if (!run) begin
         res = `TSA_CNT_IDLE;
      end else if (sync_edge) begin
         res = `TSA_CNT_FIRST;
      end else if (!cnt[9]) begin
         res = cnt + 10'h001;
      end
      return res;
   endfunction : next_count

   function automatic logic slot_hit(input logic [9:0] cnt, input logic [5:0] slot);
      return (cnt >> `TSA_SLOT_SHIFT) == {4'h0, slot};
   endfunction : slot_hit

   logic [14:0] pins_raw;
   logic [14:0] meta_q;
   logic [14:0] sync_q;

   assign pins_raw = {hardwired_identity_inputs_i, hook_state_in_i, ring_control_clear_i,
                      rx_frame_sync_i, tx_frame_sync_i, bit_rate_clock_b_i,
                      bit_rate_clock_a_i, addr_ctrl_serial_in_i, mode_slot_serial_in_i,
                      chip_select_i, serial_clock_i};

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= pins_raw;
         sync_q <= meta_q;
      end
   end

   logic sclk_s;
   logic cs_s;
   logic di_s;
   logic ad_s;
   logic clka_s;
   logic clkb_s;
   logic fst_s;
   logic fsr_s;
   logic ring_s;
   logic hook_s;
   logic [4:0] id_s;

   assign sclk_s = sync_q[0];
   assign cs_s = sync_q[1];
   assign di_s = sync_q[2];
   assign ad_s = sync_q[3];
   assign clka_s = sync_q[4];
   assign clkb_s = sync_q[5];
   assign fst_s = sync_q[6];
   assign fsr_s = sync_q[7];
   assign ring_s = sync_q[8];
   assign hook_s = sync_q[9];
   assign id_s = sync_q[14:10];

   logic sclk_prev_q;
   logic clka_prev_q;
   logic clkb_prev_q;
   logic fst_prev_q;
   logic fsr_prev_q;
   logic sclk_fall;
   logic a_step;
   logic rx_step;
   logic fst_rise;
   logic fsr_rise;

   assign sclk_fall = ce_i & sclk_prev_q & ~sclk_s;
   assign a_step = ce_i & clka_s & ~clka_prev_q;
   assign rx_step = FULL_FEATURE ? a_step : (ce_i & clkb_s & ~clkb_prev_q);
   // sync rise seen on a data clock edge
   assign fst_rise = a_step & fst_s & ~fst_prev_q;
   assign fsr_rise = rx_step & fsr_s & ~fsr_prev_q;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_prev_q <= 1'b0;
         clka_prev_q <= 1'b0;
         clkb_prev_q <= 1'b0;
      end else if (ce_i) begin
         sclk_prev_q <= sclk_s;
         clka_prev_q <= clka_s;
         clkb_prev_q <= clkb_s;
      end
   end

   // Syncs are sampled only on data clock edges, as the codec sees them
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fst_prev_q <= 1'b0;
         fsr_prev_q <= 1'b0;
      end else begin
         if (a_step) begin
            fst_prev_q <= fst_s;
         end
         if (rx_step) begin
            fsr_prev_q <= fsr_s;
         end
      end
   end

   logic [2:0] bit_cnt_q;
   logic [7:0] mode_sr_q;
   logic [7:0] ad_sr_q;
   logic [7:0] mode_nx;
   logic [7:0] ad_nx;
   logic word_done;
   logic addr_match;

   assign mode_nx = {mode_sr_q[6:0], di_s};
   assign ad_nx = {ad_sr_q[6:0], ad_s};
   assign word_done = sclk_fall & cs_s & (bit_cnt_q == `TSA_BIT_LAST);
   // address check only in the full variant
   assign addr_match = !FULL_FEATURE ||
                       (ad_nx[`TSA_ADDR_MSB:`TSA_ADDR_LSB] == id_s);

   // both words shift on the falling edge
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_cnt_q <= 3'h0;
         mode_sr_q <= 8'h00;
         ad_sr_q <= 8'h00;
      end else if (ce_i) begin
         if (!cs_s) begin
            bit_cnt_q <= 3'h0;
         end else if (sclk_fall) begin
            mode_sr_q <= mode_nx;
            ad_sr_q <= ad_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
      end
   end

   logic pend_q;
   logic [7:0] pend_word_q;
   logic [2:0] pend_ctrl_q;
   logic commit;
   tsa_mode_type pend_mode;

   assign commit = fst_rise & pend_q;
   assign pend_mode = tsa_mode_type'(pend_word_q[`TSA_MODE_FIRST:`TSA_MODE_SECOND]);

   // A new word wins over a clear in the same cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_q <= 1'b0;
         pend_word_q <= 8'h00;
         pend_ctrl_q <= `TSA_CTRL_RESET;
      end else if (ce_i) begin
         if (word_done && addr_match) begin
            pend_q <= 1'b1;
            pend_word_q <= mode_nx;
            pend_ctrl_q <= ad_nx[`TSA_CTRL_MSB:`TSA_CTRL_LSB];
         end else if (!cs_s || fst_rise) begin
            pend_q <= 1'b0;
         end
      end
   end

   logic [5:0] tx_slot_q;
   logic [5:0] rx_slot_q;
   logic [5:0] tx_slot_d;
   logic [5:0] rx_slot_d;
   logic tx_run_q;
   logic rx_run_q;
   logic tx_run_d;
   logic rx_run_d;
   logic tx_valid_q;
   logic tx_valid_d;

   // mode applied at the transmit frame sync
   always_comb begin
      tx_slot_d = tx_slot_q;
      rx_slot_d = rx_slot_q;
      tx_run_d = tx_run_q;
      rx_run_d = rx_run_q;
      tx_valid_d = tx_valid_q;
      if (commit) begin
         unique case (pend_mode)
            TSA_MODE_BOTH: begin
               tx_slot_d = pend_word_q[`TSA_SLOT_MSB:`TSA_SLOT_LSB];
               rx_slot_d = pend_word_q[`TSA_SLOT_MSB:`TSA_SLOT_LSB];
               tx_run_d = 1'b1;
               rx_run_d = 1'b1;
               tx_valid_d = 1'b1;
            end
            TSA_MODE_TX: begin
               tx_slot_d = pend_word_q[`TSA_SLOT_MSB:`TSA_SLOT_LSB];
               tx_run_d = 1'b1;
               tx_valid_d = 1'b1;
            end
            TSA_MODE_RX: begin
               rx_slot_d = pend_word_q[`TSA_SLOT_MSB:`TSA_SLOT_LSB];
               rx_run_d = 1'b1;
            end
            TSA_MODE_IDLE: begin
               tx_run_d = 1'b0;
               rx_run_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_slot_q <= `TSA_SLOT_RESET;
         rx_slot_q <= `TSA_SLOT_RESET;
         tx_run_q <= 1'b0;
         rx_run_q <= 1'b0;
         tx_valid_q <= 1'b0;
      end else if (ce_i) begin
         tx_slot_q <= tx_slot_d;
         rx_slot_q <= rx_slot_d;
         tx_run_q <= tx_run_d;
         rx_run_q <= rx_run_d;
         tx_valid_q <= tx_valid_d;
      end
   end

   logic [9:0] tx_cnt_q;
   logic [9:0] rx_cnt_q;
   logic [9:0] tx_cnt_nx;
   logic [9:0] rx_cnt_nx;
   logic tx_cnt_run;

   // Compact hook bus still needs the transmit slot while idle
   assign tx_cnt_run = tx_run_d | (!FULL_FEATURE & tx_valid_d);
   // bit counters, slot = count / 8, saturating after slot 63
   assign tx_cnt_nx = next_count(tx_cnt_q, fst_rise, tx_cnt_run);
   assign rx_cnt_nx = next_count(rx_cnt_q, fsr_rise, rx_run_d);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_cnt_q <= `TSA_CNT_IDLE;
         tx_slot_enable_o <= 1'b0;
      end else if (a_step) begin
         tx_cnt_q <= tx_cnt_nx;
         tx_slot_enable_o <= tx_run_d & slot_hit(tx_cnt_nx, tx_slot_d);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_cnt_q <= `TSA_CNT_IDLE;
         rx_slot_enable_o <= 1'b0;
      end else if (rx_step) begin
         rx_cnt_q <= rx_cnt_nx;
         rx_slot_enable_o <= rx_run_d & slot_hit(rx_cnt_nx, rx_slot_d);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_ctrl_bit_zero_o <= 1'b0;
         line_ctrl_bit_one_o <= 1'b0;
         line_ctrl_bit_two_o <= 1'b0;
         line_power_down_n_o <= `TSA_PD_RESET;
      end else if (ce_i) begin
         if (commit) begin
            line_ctrl_bit_two_o <= pend_ctrl_q[2];
            line_ctrl_bit_one_o <= pend_ctrl_q[1];
            line_ctrl_bit_zero_o <= pend_ctrl_q[0];
            // power down low only for idle mode
            line_power_down_n_o <= (pend_mode != TSA_MODE_IDLE);
         end
         if (ring_s) begin
            line_ctrl_bit_two_o <= 1'b0;
         end
      end
   end

   tsa_ack_state_type ack_state_q;
   logic [1:0] ack_cnt_q;

   // Open-drain pins only ever pull low; the value bit is constant
   assign accept_ack_n_o = 1'b0;
   assign hook_state_bus_n_o = 1'b0;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_state_q <= TSA_ACK_IDLE;
         ack_cnt_q <= 2'h0;
         accept_ack_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         unique case (ack_state_q)
            TSA_ACK_IDLE: begin
               if (commit) begin
                  ack_state_q <= TSA_ACK_WAIT;
                  ack_cnt_q <= `TSA_ACK_DELAY;
               end
            end
            TSA_ACK_WAIT: begin
               if (a_step) begin
                  ack_cnt_q <= ack_cnt_q - 2'h1;
                  if (ack_cnt_q == 2'h1) begin
                     ack_state_q <= TSA_ACK_LOW;
                     accept_ack_oe_n_o <= 1'b0;
                  end
               end
            end
            TSA_ACK_LOW: begin
               if (fst_rise) begin
                  accept_ack_oe_n_o <= 1'b1;
                  ack_state_q <= commit ? TSA_ACK_WAIT : TSA_ACK_IDLE;
                  ack_cnt_q <= `TSA_ACK_DELAY;
               end
            end
            default: begin
               ack_state_q <= TSA_ACK_IDLE;
               accept_ack_oe_n_o <= 1'b1;
            end
         endcase
      end
   end

   // compact variant only: hook bus pulled low when hook input high in transmit slot
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hook_state_bus_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         hook_state_bus_oe_n_o <= !(!FULL_FEATURE && tx_valid_q && hook_s &&
                                    slot_hit(tx_cnt_q, tx_slot_q));
      end
   end

   // Helper counters for the checks below
   logic [3:0] txe_len_q;
   logic [3:0] since_fst_q;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         txe_len_q <= 4'h0;
         since_fst_q <= 4'hf;
      end else begin
         if (!tx_slot_enable_o) begin
            txe_len_q <= 4'h0;
         end else if (a_step) begin
            txe_len_q <= txe_len_q + 4'h1;
         end
         if (fst_rise) begin
            since_fst_q <= 4'h0;
         end else if (a_step && since_fst_q != 4'hf) begin
            since_fst_q <= since_fst_q + 4'h1;
         end
      end
   end

   a_shift_count: assert property (
      cs_s && sclk_fall && bit_cnt_q != `TSA_BIT_LAST
      |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
      else $error("serial bit count did not advance");

   a_cs_clear_port: assert property (
      ce_i && !cs_s && !(word_done && addr_match) |=> bit_cnt_q == 3'h0 && !pend_q)
      else $error("chip select low did not clear the port");

   a_addr_reject: assert property (
      FULL_FEATURE && word_done && !addr_match && !fst_rise && cs_s
      |=> pend_q == $past(pend_q))
      else $error("word taken despite address mismatch");

   a_ring_clear_bit: assert property (
      ce_i && ring_s |=> !line_ctrl_bit_two_o)
      else $error("ring clear did not force bit two low");

   a_ack_delay_three: assert property (
      $fell(accept_ack_oe_n_o) |-> since_fst_q == 4'h3)
      else $error("acknowledge not three data clocks after sync");

   a_ack_release_sync: assert property (
      fst_rise && !accept_ack_oe_n_o |=> accept_ack_oe_n_o)
      else $error("acknowledge not released on frame sync");

   a_txe_eight_wide: assert property (
      $fell(tx_slot_enable_o) |-> txe_len_q == 4'h8)
      else $error("transmit enable not eight data clocks wide");

   a_txe_slot_start: assert property (
      $rose(tx_slot_enable_o) |-> tx_cnt_q == {1'b0, tx_slot_q, 3'h0})
      else $error("transmit enable outside its slot");

   a_idle_stops_out: assert property (
      commit && pend_mode == TSA_MODE_IDLE
      |=> !tx_run_q && !rx_run_q ##1 !rx_slot_enable_o)
      else $error("idle mode left an enable running");

   a_slot_load_tx: assert property (
      commit && pend_mode == TSA_MODE_TX
      |=> tx_slot_q == $past(pend_word_q[`TSA_SLOT_MSB:`TSA_SLOT_LSB]))
      else $error("transmit slot not loaded on frame sync");

   a_power_down_mode: assert property (
      commit |=> line_power_down_n_o == ($past(pend_mode) != TSA_MODE_IDLE))
      else $error("power down output mismatches mode");

   c_word_accepted: cover property (word_done && addr_match);
   c_ack_low: cover property ($fell(accept_ack_oe_n_o));
   c_txe_pulse: cover property ($fell(tx_slot_enable_o));
   c_idle_mode: cover property (commit && pend_mode == TSA_MODE_IDLE);

endmodule : tsa_slot_assigner

`default_nettype wire

// ==== tsa_proc_port_model.sv ====
// Processor-side model of the serial programming port
`timescale 1ns/10ps
`default_nettype none

module tsa_proc_port_model (
   input wire logic clock_i,
   input wire logic ack_pin_i,
   output var logic sclk_o,
   output var logic cs_o,
   output var logic di_o,
   output var logic ad_o
);
   initial begin
      sclk_o = 1'b0;
      cs_o = 1'b0;
      di_o = 1'b0;
      ad_o = 1'b0;
   end

   task automatic send(input logic [7:0] dw, input logic [7:0] aw, output logic acked);
      int n;
      acked = 1'b0;
      @(negedge clock_i);
      cs_o = 1'b1;
      repeat (6) @(negedge clock_i);
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b1;
         di_o = dw[i];
         ad_o = aw[i];
         repeat (6) @(negedge clock_i);
         sclk_o = 1'b0;
         repeat (6) @(negedge clock_i);
      end
      // Flipped so stale data never looks valid
      di_o = ~di_o;
      ad_o = ~ad_o;
      for (n = 0; n < 7000 && !acked; n++) begin
         @(negedge clock_i);
         acked = (ack_pin_i === 1'b0);
      end
      cs_o = 1'b0;
   endtask : send
endmodule : tsa_proc_port_model

`default_nettype wire

// ==== tsa_slot_assigner_tb_top.sv ====
// Self-checking bench for the time slot assigner, full and compact variants
`timescale 1ns/10ps
`default_nettype none

module tsa_slot_assigner_tb_top;
   // Short frame of 16 slots keeps the run brief
   localparam logic [1:0] MD [0:4] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
   localparam logic [5:0] SL [0:4] = '{6'h02, 6'h05, 6'h0f, 6'h09, 6'h00};
   localparam logic [2:0] CT [0:4] = '{3'h5, 3'h2, 3'h3, 3'h7, 3'h0};
   localparam logic [2:0] EC [0:4] = '{3'h5, 3'h2, 3'h3, 3'h3, 3'h0};
   localparam logic [0:0] BAD [0:4] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
   localparam logic [0:0] ON [0:4] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
   localparam logic [9:0] ETX [0:4] = '{10'h010, 10'h028, 10'h028, 10'h028, 10'h000};
   localparam logic [9:0] ERX [0:4] = '{10'h010, 10'h010, 10'h078, 10'h078, 10'h000};
   // Compact hook slot: no address check, hook input low in step 2, kept while idle
   localparam logic [9:0] EHK [0:4] = '{10'h010, 10'h028, 10'h07f, 10'h048, 10'h048};
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ring_clr = 1'b0;
   logic dclk = 1'b0;
   logic tx_frame_sync = 1'b0;
   logic rx_frame_sync = 1'b0;
   logic [4:0] ident = 5'h0b;
   logic [3:0] ph = 4'hf;
   logic [6:0] bit_idx = 7'h7f;
   logic sclk;
   logic cs;
   logic di;
   logic ad;
   logic tx_slot_enable;
   logic rx_slot_enable;
   logic q0;
   logic q1;
   logic q2;
   logic pdn;
   logic ack_n;
   logic ack_oe_n;
   logic hook_n;
   logic hook_oe_n;
   logic hook_in = 1'b1;
   logic q0_c;
   logic q1_c;
   logic q2_c;
   logic pdn_c;
   logic hook_oe_c;
   logic hk_p = 1'b1;
   logic [6:0] hook_bit = 7'h7f;
   logic [6:0] hook_at = 7'h7f;
   logic txe_p = 1'b0;
   logic rxe_p = 1'b0;
   logic ack_p = 1'b1;
   logic [6:0] tx_rise = 7'h00;
   logic [6:0] rx_rise = 7'h00;
   logic [6:0] ack_fall = 7'h7f;
   logic [6:0] ack_rise = 7'h7f;
   logic [9:0] tx_len = 10'h000;
   logic [3:0] tx_n = 4'h0;
   logic [3:0] rx_n = 4'h0;
   logic [3:0] tx_cnt = 4'h0;
   logic [3:0] rx_cnt = 4'h0;
   logic [3:0] ack_falls = 4'h0;
   logic [3:0] falls;
   logic acked;
   int cycles = 0;
   int errors = 0;
   int check_count = 0;
   // Open-drain acknowledge with pull-up
   wire ack_pin = ack_oe_n ? 1'b1 : ack_n;

   always #4 clock_i = ~clock_i;

   tsa_proc_port_model u_proc (
      .clock_i(clock_i),
      .ack_pin_i(ack_pin),
      .sclk_o(sclk),
      .cs_o(cs),
      .di_o(di),
      .ad_o(ad)
   );

   tsa_slot_assigner #(.FULL_FEATURE(1'b1)) u_dut (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .ce_i(1'b1),
      .serial_clock_i(sclk),
      .chip_select_i(cs),
      .mode_slot_serial_in_i(di),
      .addr_ctrl_serial_in_i(ad),
      .hardwired_identity_inputs_i(ident),
      .ring_control_clear_i(ring_clr),
      .bit_rate_clock_a_i(dclk),
      .bit_rate_clock_b_i(1'b0),
      .tx_frame_sync_i(tx_frame_sync),
      .rx_frame_sync_i(rx_frame_sync),
      .hook_state_in_i(hook_in),
      .tx_slot_enable_o(tx_slot_enable),
      .rx_slot_enable_o(rx_slot_enable),
      .line_ctrl_bit_zero_o(q0),
      .line_ctrl_bit_one_o(q1),
      .line_ctrl_bit_two_o(q2),
      .line_power_down_n_o(pdn),
      .accept_ack_n_o(ack_n),
      .accept_ack_oe_n_o(ack_oe_n),
      .hook_state_bus_n_o(hook_n),
      .hook_state_bus_oe_n_o(hook_oe_n)
   );

   // Compact variant on the same port; its acknowledge stays off the shared pin
   tsa_slot_assigner #(.FULL_FEATURE(1'b0)) u_dut_compact (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .ce_i(1'b1),
      .serial_clock_i(sclk),
      .chip_select_i(cs),
      .mode_slot_serial_in_i(di),
      .addr_ctrl_serial_in_i(ad),
      .hardwired_identity_inputs_i(ident),
      .ring_control_clear_i(ring_clr),
      .bit_rate_clock_a_i(dclk),
      .bit_rate_clock_b_i(dclk),
      .tx_frame_sync_i(tx_frame_sync),
      .rx_frame_sync_i(rx_frame_sync),
      .hook_state_in_i(hook_in),
      .tx_slot_enable_o(),
      .rx_slot_enable_o(),
      .line_ctrl_bit_zero_o(q0_c),
      .line_ctrl_bit_one_o(q1_c),
      .line_ctrl_bit_two_o(q2_c),
      .line_power_down_n_o(pdn_c),
      .accept_ack_n_o(),
      .accept_ack_oe_n_o(),
      .hook_state_bus_n_o(),
      .hook_state_bus_oe_n_o(hook_oe_c)
   );

   task automatic end_sim();
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check_val

   task automatic wait_frames(input int n);
      repeat (n) @(posedge tx_frame_sync);
      repeat (4) @(negedge clock_i);
   endtask : wait_frames

   // Data clock of 16 system clocks; receive frame 3 bits behind transmit
   always @(negedge clock_i) begin
      ph = ph + 4'h1;
      dclk = (ph < 4'h8);
      if (ph == 4'h0) begin
         bit_idx = bit_idx + 7'h01;
         tx_frame_sync = (bit_idx == 7'h00);
         rx_frame_sync = (bit_idx == 7'h03);
         if (tx_frame_sync) begin
            tx_cnt = tx_n;
            rx_cnt = rx_n;
            tx_n = 4'h0;
            rx_n = 4'h0;
            hook_at = hook_bit;
            hook_bit = 7'h7f;
         end
      end
      if (tx_slot_enable === 1'b1 && txe_p === 1'b0) begin
         tx_rise = bit_idx;
         tx_n = tx_n + 4'h1;
         tx_len = 10'h000;
      end
      if (tx_slot_enable === 1'b1) begin
         tx_len = tx_len + 10'h001;
      end
      if (rx_slot_enable === 1'b1 && rxe_p === 1'b0) begin
         rx_rise = bit_idx - 7'h03;
         rx_n = rx_n + 4'h1;
      end
      if (ack_pin === 1'b0 && ack_p === 1'b1) begin
         ack_fall = bit_idx;
         ack_falls = ack_falls + 4'h1;
      end
      if (ack_pin === 1'b1 && ack_p === 1'b0) begin
         ack_rise = bit_idx;
      end
      if (hook_oe_c === 1'b0 && hk_p === 1'b1) begin
         hook_bit = bit_idx;
      end
      hk_p = hook_oe_c;
      txe_p = tx_slot_enable;
      rxe_p = rx_slot_enable;
      ack_p = ack_pin;
      cycles++;
      if (cycles == 90000) begin
         errors++;
         end_sim();
      end
   end

   initial begin
      repeat (8) @(negedge clock_i);
      rstn_i = 1'b1;
      wait_frames(1);
      check_val("idle", 10'h007, {2'h0, tx_slot_enable, rx_slot_enable, q2, q1, q0, pdn, ack_oe_n, hook_oe_n});
      check_val("hook bus value", 10'h000, {9'h000, hook_n});
      for (int k = 0; k < 5; k++) begin
         falls = ack_falls;
         hook_in = (k != 2);
         u_proc.send({MD[k], SL[k]}, {CT[k], ident ^ {4'h0, BAD[k]}}, acked);
         wait_frames(2);
         check_val("ack seen", {9'h000, ~BAD[k]}, {9'h000, acked});
         check_val("ack count", {9'h000, ~BAD[k]}, {6'h00, ack_falls - falls});
         if (!BAD[k]) begin
            check_val("ack fall bit", 10'h003, {3'h0, ack_fall});
            check_val("ack rise bit", 10'h000, {3'h0, ack_rise});
         end
         check_val("line ctrl", {7'h00, EC[k]}, {7'h00, q2, q1, q0});
         check_val("power down", {9'h000, ON[k]}, {9'h000, pdn});
         check_val("compact ctrl", {7'h00, CT[k]}, {7'h00, q2_c, q1_c, q0_c});
         check_val("compact power down", {9'h000, ON[k]}, {9'h000, pdn_c});
         check_val("compact hook bit", EHK[k], {3'h0, hook_at});
         check_val("tx per frame", {9'h000, ON[k]}, {6'h00, tx_cnt});
         check_val("rx per frame", {9'h000, ON[k]}, {6'h00, rx_cnt});
         if (ON[k]) begin
            check_val("tx slot bit", ETX[k], {3'h0, tx_rise});
            check_val("rx slot bit", ERX[k], {3'h0, rx_rise});
            check_val("tx slot len", 10'h080, tx_len);
         end
         if (k == 0) begin
            ring_clr = 1'b1;
            repeat (8) @(negedge clock_i);
            check_val("ring clear bit two", 10'h000, {9'h000, q2});
            check_val("ring clear bit zero", 10'h001, {9'h000, q0});
            check_val("compact ring clear", 10'h000, {9'h000, q2_c});
            ring_clr = 1'b0;
         end
      end
      end_sim();
   end
endmodule : tsa_slot_assigner_tb_top

`default_nettype wire
